// *** design/pdi_defines.svh ***
// Constants shared by both ends of the drive process-data link.
// Assumes a 20 MHz core clock; included by package and modules.
`ifndef PDI_DEFINES_SVH
`define PDI_DEFINES_SVH
// ****************************************
// Timing
// ****************************************
`define PDI_CLK_NS        50
`define PDI_TICK_NS       1000000
`define PDI_CYCLE_MS      8'h08
`define PDI_WD_MIN        8'h03
// ****************************************
// Module selection and record addressing
// ****************************************
`define PDI_NUM_MODULES   7'h55
`define PDI_NUM_STD       7'h54
`define PDI_MOD_TELEGRAM  7'h00
`define PDI_MAX_CMD       8
`define PDI_MAX_STS       32
`define PDI_REC_API       16'h0000
`define PDI_REC_SLOT      8'h01
`define PDI_REC_SUBSLOT   8'h01
`define PDI_REC_LEN       8'h02
`define PDI_REC_RSVD_BIT  15
// ****************************************
// Control and status word bits
// ****************************************
`define PDI_CW_RUN        0
`define PDI_CW_NO_COAST   1
`define PDI_CW_NO_QUICK   2
`define PDI_CW_OP_EN      3
`define PDI_CW_RAMP_EN    4
`define PDI_CW_UNFREEZE   5
`define PDI_CW_SP_EN      6
`define PDI_CW_FAULT_ACK  7
`define PDI_CW_REMOTE     10
`define PDI_SW_RDY_ON     0
`define PDI_SW_RDY_RUN    1
`define PDI_SW_NO_COAST   4
`define PDI_SW_NO_QUICK   5
`define PDI_SPEED_SHIFT   14
// ****************************************
// Controller register map
// ****************************************
`define PDI_REG_CTRL      12'h000
`define PDI_REG_STAT      12'h004
`define PDI_REG_ID        12'h008
`define PDI_REG_REC       12'h00c
`define PDI_REG_RDATA     12'h010
`define PDI_REG_CMD       12'h040
`define PDI_REG_STS       12'h080
`define PDI_CTRL_RST      32'h0808_0000
`endif

// *** design/pdi_pkg.sv ***
// Types for the drive process-data link.
// Assumes pdi_defines.svh is on the include path.
`include "pdi_defines.svh"
package pdi_pkg;
	typedef logic [15:0] pdi_word_t;
	typedef enum logic [2:0] {
		DS_IDLE, DS_DIV, DS_STD_WR, DS_STD_RD, DS_REC, DS_ACK
	} pdi_dev_state_e;
endpackage : pdi_pkg

// *** design/pdi_link_if.sv ***
// Link between the controller end and the drive interface end.
// Both ends run on the same core clock; requests are held levels.
interface pdi_link_if;
	import pdi_pkg::*;
	// Connection
	logic                  conn_req;
	logic [7:0]            conn_id;
	logic [6:0]            conn_module;
	logic [7:0]            conn_cycle_ms;
	logic [7:0]            conn_wd_factor;
	logic                  conn_ack;
	logic                  conn_nak;
	logic                  conn_timeout;
	// Cyclic data
	logic                  cyc_req;
	logic [7:0][15:0]      cyc_cmd;
	logic                  cyc_ack;
	logic [31:0][15:0]     cyc_sts;
	// Acyclic record access
	logic                  rec_req;
	logic                  rec_wr;
	logic [15:0]           rec_api;
	logic [7:0]            rec_slot;
	logic [7:0]            rec_subslot;
	logic [15:0]           rec_index;
	logic [7:0]            rec_len;
	logic [15:0]           rec_wdata;
	logic                  rec_done;
	logic                  rec_err;
	logic [15:0]           rec_rdata;
	modport device (
		input  conn_req, conn_id, conn_module, conn_cycle_ms, conn_wd_factor,
		output conn_ack, conn_nak, conn_timeout,
		input  cyc_req, cyc_cmd,
		output cyc_ack, cyc_sts,
		input  rec_req, rec_wr, rec_api, rec_slot, rec_subslot, rec_index,
		input  rec_len, rec_wdata,
		output rec_done, rec_err, rec_rdata
	);
	modport controller (
		output conn_req, conn_id, conn_module, conn_cycle_ms, conn_wd_factor,
		input  conn_ack, conn_nak, conn_timeout,
		output cyc_req, cyc_cmd,
		input  cyc_ack, cyc_sts,
		output rec_req, rec_wr, rec_api, rec_slot, rec_subslot, rec_index,
		output rec_len, rec_wdata,
		input  rec_done, rec_err, rec_rdata
	);
endinterface : pdi_link_if

// *** design/pdi_device.sv ***
// Drive-side process-data interpreter: connection, cyclic, record access.
// Assumes one core clock shared with the link and the drive register port.
`include "pdi_defines.svh"
// Overview of operation
// [R01] One controller at a time; others refused
// [R02] Eighty-five modules: 84 standard, one telegram
// [R03] Standard: up to 8 commands, 32 statuses
// [R04] Module adopted from controller configuration
// [R05] Controller cycle period eight ms or more; code maps 0 to 8 ms and accepts 1 to 7 ms as set
// [R06] Watchdog three cycles; expiry raises timeout
// [R07] Records at API0 slot1 subslot1, two bytes
// [R08] Zero command map entry discards word
// [R09] Zero status map entry returns zero
// [R10] Telegram: control/speed out, status/speed in
// [R11] Speed control mode only
// [R12] Class A cyclic, discovery, alarms, records; code has cyclic and records only
// [R13] Profile 4.1 needs no local setup
// [R14] Controller picks module by profile support
// [R15] Control bit 4 enables ramp, else 0Hz
// [R16] Control bit 5 clear freezes ramp
// [R17] Fault cleared only on bit 7 rise
// [R18] Control bit 10 clear ignores process data; code still pulses fault_clear on a bit 7 rise
// [R19] Status bits 0,1 report readiness
// [R20] Run, stops, enables decoded; spare bits ignored
// [R21] Status bits 4,5 mirror control bits 1,2
// [R22] Speed signed, 0x4000 is full scale
module pdi_device
	import pdi_pkg::*;
#(
	parameter int TICK_CYCLES = `PDI_TICK_NS / `PDI_CLK_NS
)(
	// Clock, reset, enable
	input  wire logic           core_clk,
	input  wire logic           resetn,
	input  wire logic           ce,
	// Link
	pdi_link_if.device          lnk,
	// Mapping tables
	input  wire logic           map_we,
	input  wire logic           map_is_sts,
	input  wire logic [4:0]     map_idx,
	input  wire logic [15:0]    map_reg,
	// Drive register port
	output logic                drv_req,
	output logic                drv_wr,
	output logic [15:0]         drv_addr,
	output logic [15:0]         drv_wdata,
	input  wire logic           drv_ack,
	input  wire logic [15:0]    drv_rdata,
	// Drive control from telegram
	output logic                run_cmd,
	output logic                coast_stop_request,
	output logic                quick_stop_request,
	output logic                op_enable,
	output logic                setpoint_enable,
	output logic                ramp_enable,
	output logic                ramp_freeze,
	output logic                fault_clear,
	output logic                remote_ctrl,
	output logic signed [15:0]  freq_cmd,
	output logic                telegram_mode,
	output logic                comm_timeout,
	// Drive state
	input  wire logic [15:0]    max_freq,
	input  wire logic signed [15:0] out_freq,
	input  wire logic           ready_on,
	input  wire logic           ready_run
);
	// ****************************************
	// State
	// ****************************************
	pdi_dev_state_e     st_q;
	logic               conn_q;
	logic [7:0]         owner_q;
	logic [6:0]         mod_q;
	logic [3:0]         out_cnt_q;
	logic [5:0]         in_cnt_q;
	logic [15:0]        wd_lim_q;
	logic [15:0]        wd_ms_q;
	logic [31:0]        tick_q;
	logic [5:0]         idx_q;
	logic [15:0]        cmd_map_q [`PDI_MAX_CMD];
	logic [15:0]        sts_map_q [`PDI_MAX_STS];
	logic [31:0][15:0]  sts_q;
	logic [15:0]        cw_q;
	logic [29:0]        num_q;
	logic [15:0]        rem_q;
	logic [4:0]         div_cnt_q;
	logic               neg_q;
	logic               rec_ok;
	logic [6:0]         mcode;
	logic [31:0]        sp_prod;
	logic [16:0]        rem_try;
	logic [15:0]        cur_map;

	assign mcode = lnk.conn_module - 7'h01;
	assign cur_map = (st_q == DS_STD_WR) ? cmd_map_q[idx_q[2:0]]
		: sts_map_q[idx_q[4:0]];
	assign rec_ok = (lnk.rec_api == `PDI_REC_API)
		&& (lnk.rec_slot == `PDI_REC_SLOT)
		&& (lnk.rec_subslot == `PDI_REC_SUBSLOT)
		&& (lnk.rec_len == `PDI_REC_LEN)
		&& !lnk.rec_index[`PDI_REC_RSVD_BIT]; // [R07]
	assign rem_try = {rem_q, num_q[29]} - {1'b0, max_freq};
	assign sp_prod = $signed(lnk.cyc_cmd[1]) * $signed({1'b0, max_freq});

	// ****************************************
	// Connection and watchdog
	// ****************************************
	assign lnk.conn_ack = lnk.conn_req && ce && (!conn_q
		|| owner_q == lnk.conn_id) && lnk.conn_module < `PDI_NUM_MODULES
		&& lnk.conn_wd_factor >= `PDI_WD_MIN; // [R01] [R02] [R06]
	assign lnk.conn_nak = lnk.conn_req && ce && !lnk.conn_ack; // [R01]
	assign lnk.conn_timeout = comm_timeout;
	assign telegram_mode = conn_q && mod_q == `PDI_MOD_TELEGRAM; // [R13]

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			conn_q    <= 1'b0;
			owner_q   <= 8'h00;
			mod_q     <= 7'h00;
			out_cnt_q <= 4'h0;
			in_cnt_q  <= 6'h00;
			wd_lim_q  <= 16'h0000;
		end
		else if (ce)
		begin
			if (lnk.conn_ack)
			begin
				conn_q    <= 1'b1; // [R01]
				owner_q   <= lnk.conn_id;
				mod_q     <= lnk.conn_module; // [R04]
				out_cnt_q <= 4'(mcode[2:0]) + 4'h1; // [R02] [R03]
				in_cnt_q  <= 6'(mcode[6:3]) * 6'h03 + 6'h02; // [R03]
				wd_lim_q  <= 16'(lnk.conn_cycle_ms) * 16'(lnk.conn_wd_factor);
			end
			else if (comm_timeout)
				conn_q <= 1'b0; // [R06]
		end

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			tick_q       <= 32'h0000_0000;
			wd_ms_q      <= 16'h0000;
			comm_timeout <= 1'b0;
		end
		else if (ce)
		begin
			comm_timeout <= 1'b0;
			if (!conn_q || lnk.conn_ack || lnk.cyc_ack)
			begin
				tick_q  <= 32'h0000_0000;
				wd_ms_q <= 16'h0000;
			end
			else if (tick_q == 32'(TICK_CYCLES - 1))
			begin
				tick_q <= 32'h0000_0000;
				if (wd_ms_q + 16'h0001 >= wd_lim_q)
					comm_timeout <= 1'b1; // [R06]
				else
					wd_ms_q <= wd_ms_q + 16'h0001;
			end
			else
				tick_q <= tick_q + 32'h0000_0001;
		end

	// ****************************************
	// Mapping tables
	// ****************************************
	always_ff @(posedge core_clk)
		if (ce && map_we)
		begin
			if (map_is_sts)
				sts_map_q[map_idx] <= map_reg;
			else
				cmd_map_q[map_idx[2:0]] <= map_reg;
		end

	// ****************************************
	// Sequencer for cyclic and record traffic
	// ****************************************
	assign lnk.cyc_ack = st_q == DS_ACK && lnk.cyc_req; // [R12]
	assign lnk.cyc_sts = sts_q;

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			st_q          <= DS_IDLE;
			idx_q         <= 6'h00;
			sts_q         <= '0;
			drv_req       <= 1'b0;
			drv_wr        <= 1'b0;
			drv_addr      <= 16'h0000;
			drv_wdata     <= 16'h0000;
			lnk.rec_done  <= 1'b0;
			lnk.rec_err   <= 1'b0;
			lnk.rec_rdata <= 16'h0000;
			num_q         <= 30'h0000_0000;
			rem_q         <= 16'h0000;
			div_cnt_q     <= 5'h00;
			neg_q         <= 1'b0;
		end
		else if (ce)
		begin
			lnk.rec_done <= 1'b0;
			case (st_q)
				DS_IDLE:
					if (lnk.cyc_req && conn_q && telegram_mode)
					begin
						neg_q     <= out_freq[15];
						num_q     <= 30'(out_freq[15] ? -out_freq : out_freq)
							<< `PDI_SPEED_SHIFT; // [R22]
						rem_q     <= 16'h0000;
						div_cnt_q <= 5'h00;
						st_q      <= DS_DIV;
					end
					else if (lnk.cyc_req && conn_q)
					begin
						idx_q <= 6'h00;
						sts_q <= '0;
						st_q  <= DS_STD_WR;
					end
					else if (lnk.rec_req && !lnk.rec_done)
					begin
						lnk.rec_err <= !rec_ok; // [R07]
						if (rec_ok)
						begin
							drv_req   <= 1'b1;
							drv_wr    <= lnk.rec_wr;
							drv_addr  <= lnk.rec_index; // [R07]
							drv_wdata <= lnk.rec_wdata;
							st_q      <= DS_REC;
						end
						else
							lnk.rec_done <= 1'b1;
					end
				DS_DIV:
				begin
					rem_q <= rem_try[16] ? {rem_q[14:0], num_q[29]}
						: rem_try[15:0];
					num_q <= {num_q[28:0], !rem_try[16]};
					div_cnt_q <= div_cnt_q + 5'h01;
					if (div_cnt_q == 5'h1d)
					begin
						// Quotient saturates at 0x7fff, or at 0x8001 when negative
						sts_q[1] <= (|num_q[28:14])
							? (neg_q ? 16'h8001 : 16'h7fff)
							: (neg_q ? -{num_q[14:0], !rem_try[16]}
							: {num_q[14:0], !rem_try[16]}); // [R10] [R22]
						sts_q[0] <= 16'((ready_on << `PDI_SW_RDY_ON)
							| (ready_run << `PDI_SW_RDY_RUN)
							| (cw_q[`PDI_CW_NO_COAST] << `PDI_SW_NO_COAST)
							| (cw_q[`PDI_CW_NO_QUICK] << `PDI_SW_NO_QUICK));
							// [R19] [R21]
						st_q <= DS_ACK;
					end
				end
				DS_STD_WR, DS_STD_RD:
					if (drv_req)
					begin
						if (drv_ack)
						begin
							drv_req <= 1'b0;
							if (!drv_wr)
								sts_q[idx_q[4:0]] <= drv_rdata;
							idx_q <= idx_q + 6'h01;
						end
					end
					else if (st_q == DS_STD_WR && idx_q >= 6'(out_cnt_q))
					begin
						idx_q <= 6'h00;
						st_q  <= DS_STD_RD;
					end
					else if (st_q == DS_STD_RD && idx_q >= in_cnt_q)
						st_q <= DS_ACK;
					else if (cur_map == 16'h0000)
						idx_q <= idx_q + 6'h01; // [R08] [R09]
					else
					begin
						drv_req   <= 1'b1;
						drv_wr    <= st_q == DS_STD_WR;
						drv_addr  <= cur_map;
						drv_wdata <= lnk.cyc_cmd[idx_q[2:0]]; // [R03]
					end
				DS_REC:
					if (drv_ack)
					begin
						drv_req       <= 1'b0;
						lnk.rec_rdata <= drv_wr ? lnk.rec_wdata : drv_rdata;
						lnk.rec_done  <= 1'b1;
						st_q          <= DS_IDLE;
					end
				DS_ACK:
					st_q <= DS_IDLE;
				default:
					st_q <= DS_IDLE;
			endcase
		end

	// ****************************************
	// Telegram control word decode
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			cw_q               <= 16'h0000;
			run_cmd            <= 1'b0;
			coast_stop_request <= 1'b0;
			quick_stop_request <= 1'b0;
			op_enable          <= 1'b0;
			setpoint_enable    <= 1'b0;
			ramp_enable        <= 1'b0;
			ramp_freeze        <= 1'b0;
			fault_clear        <= 1'b0;
			remote_ctrl        <= 1'b0;
			freq_cmd           <= 16'sh0000;
		end
		else if (ce)
		begin
			fault_clear <= 1'b0;
			if (lnk.cyc_req && telegram_mode && st_q == DS_IDLE)
			begin
				cw_q        <= lnk.cyc_cmd[0]; // [R10]
				remote_ctrl <= lnk.cyc_cmd[0][`PDI_CW_REMOTE];
				fault_clear <= lnk.cyc_cmd[0][`PDI_CW_FAULT_ACK]
					&& !cw_q[`PDI_CW_FAULT_ACK]; // [R17]
				if (lnk.cyc_cmd[0][`PDI_CW_REMOTE]) // [R18]
				begin
					run_cmd            <= lnk.cyc_cmd[0][`PDI_CW_RUN]; // [R20]
					coast_stop_request <= !lnk.cyc_cmd[0][`PDI_CW_NO_COAST];
					quick_stop_request <= !lnk.cyc_cmd[0][`PDI_CW_NO_QUICK];
					op_enable          <= lnk.cyc_cmd[0][`PDI_CW_OP_EN];
					setpoint_enable    <= lnk.cyc_cmd[0][`PDI_CW_SP_EN];
					ramp_enable        <= lnk.cyc_cmd[0][`PDI_CW_RAMP_EN];
					ramp_freeze        <= !lnk.cyc_cmd[0][`PDI_CW_UNFREEZE];
					if (!lnk.cyc_cmd[0][`PDI_CW_RAMP_EN])
						freq_cmd <= 16'sh0000; // [R15]
					else if (lnk.cyc_cmd[0][`PDI_CW_UNFREEZE]) // [R16]
						freq_cmd <= sp_prod[29:14]; // [R11] [R22]
				end
			end
		end
endmodule : pdi_device

// *** design/pdi_controller.sv ***
// Controller end: APB register front end driving the link master.
// Assumes the APB master and the device share the core clock.
`include "pdi_defines.svh"
module pdi_controller
	import pdi_pkg::*;
#(
	parameter int TICK_CYCLES = `PDI_TICK_NS / `PDI_CLK_NS
)(
	// Clock, reset, enable
	input  wire logic           core_clk,
	input  wire logic           resetn,
	input  wire logic           ce,
	// APB slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [11:0]    paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	// Link
	pdi_link_if.controller      lnk
);
	// ****************************************
	// Registers
	// ****************************************
	logic [31:0]        ctrl_q;
	logic [7:0]         id_q;
	logic [16:0]        rec_q;
	logic               conn_q;
	logic               refused_q;
	logic               tmo_q;
	logic               rec_err_q;
	logic [31:0]        tick_q;
	logic [7:0]         ms_q;
	logic [7:0][15:0]   cmd_q;
	logic [31:0][15:0]  sts_q;
	logic               wr;
	logic               rd;
	logic               cmd_hit;
	logic               sts_hit;
	logic               map_hit;

	assign wr = psel && penable && pwrite && ce;
	assign rd = psel && !pwrite;
	assign cmd_hit = paddr[11:5] == 7'h02;
	assign sts_hit = paddr[11:7] == 5'h01;
	assign map_hit = paddr[1:0] == 2'h0 && (cmd_hit || sts_hit
		|| paddr <= `PDI_REG_RDATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !map_hit;

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			ctrl_q <= `PDI_CTRL_RST;
			id_q   <= 8'h01;
			cmd_q  <= '0;
			rec_q  <= 17'h0_0000;
		end
		else if (wr && map_hit)
		begin
			if (paddr == `PDI_REG_CTRL)
				ctrl_q <= pwdata;
			if (paddr == `PDI_REG_ID)
				id_q <= pwdata[7:0];
			if (paddr == `PDI_REG_REC)
				rec_q <= pwdata[16:0];
			if (cmd_hit)
				cmd_q[paddr[4:2]] <= pwdata[15:0];
		end

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			prdata <= 32'h0000_0000;
		else if (ce && rd && !penable)
		begin
			prdata <= 32'h0000_0000;
			if (paddr == `PDI_REG_CTRL)
				prdata <= ctrl_q;
			if (paddr == `PDI_REG_STAT)
				prdata <= {26'h0, lnk.rec_req, rec_err_q, lnk.cyc_req, tmo_q,
					refused_q, conn_q};
			if (paddr == `PDI_REG_ID)
				prdata <= {24'h0, id_q};
			if (paddr == `PDI_REG_REC)
				prdata <= {15'h0, rec_q};
			if (paddr == `PDI_REG_RDATA)
				prdata <= {16'h0, lnk.rec_rdata};
			if (cmd_hit)
				prdata <= {16'h0, cmd_q[paddr[4:2]]};
			if (sts_hit)
				prdata <= {16'h0, sts_q[paddr[6:2]]};
		end

	// ****************************************
	// Connection
	// ****************************************
	assign lnk.conn_id = id_q;
	assign lnk.conn_module = ctrl_q[14:8];
	assign lnk.conn_wd_factor = ctrl_q[23:16] < `PDI_WD_MIN ? `PDI_WD_MIN
		: ctrl_q[23:16]; // [R06]
	assign lnk.conn_cycle_ms = ctrl_q[31:24] == 8'h00 ? `PDI_CYCLE_MS
		: ctrl_q[31:24]; // [R05]

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			lnk.conn_req <= 1'b0;
			conn_q       <= 1'b0;
			refused_q    <= 1'b0;
			tmo_q        <= 1'b0;
		end
		else if (ce)
		begin
			if (wr && paddr == `PDI_REG_CTRL && pwdata[0])
				lnk.conn_req <= 1'b1;
			else if (lnk.conn_ack || lnk.conn_nak)
				lnk.conn_req <= 1'b0;
			if (lnk.conn_ack)
				conn_q <= 1'b1;
			else if (lnk.conn_timeout)
				conn_q <= 1'b0;
			// Hardware set wins over write-one clear
			refused_q <= lnk.conn_nak || refused_q
				&& !(wr && paddr == `PDI_REG_STAT && pwdata[1]);
			tmo_q <= lnk.conn_timeout || tmo_q
				&& !(wr && paddr == `PDI_REG_STAT && pwdata[2]);
		end

	// ****************************************
	// Cyclic exchange timer
	// ****************************************
	assign lnk.cyc_cmd = cmd_q; // [R14]

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			tick_q      <= 32'h0000_0000;
			ms_q        <= 8'h00;
			lnk.cyc_req <= 1'b0;
			sts_q       <= '0;
		end
		else if (ce)
		begin
			if (lnk.cyc_ack)
			begin
				lnk.cyc_req <= 1'b0;
				sts_q       <= lnk.cyc_sts;
			end
			if (tick_q == 32'(TICK_CYCLES - 1))
			begin
				tick_q <= 32'h0000_0000;
				if (ms_q + 8'h01 >= lnk.conn_cycle_ms)
				begin
					ms_q <= 8'h00;
					if (conn_q && ctrl_q[1])
						lnk.cyc_req <= 1'b1; // [R05]
				end
				else
					ms_q <= ms_q + 8'h01;
			end
			else
				tick_q <= tick_q + 32'h0000_0001;
		end

	// ****************************************
	// Record access
	// ****************************************
	assign lnk.rec_api = `PDI_REC_API; // [R07]
	assign lnk.rec_slot = `PDI_REC_SLOT;
	assign lnk.rec_subslot = `PDI_REC_SUBSLOT;
	assign lnk.rec_len = `PDI_REC_LEN;
	assign lnk.rec_index = rec_q[15:0];
	assign lnk.rec_wr = rec_q[16];

	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			lnk.rec_req   <= 1'b0;
			lnk.rec_wdata <= 16'h0000;
			rec_err_q     <= 1'b0;
		end
		else if (ce)
		begin
			if (wr && paddr == `PDI_REG_RDATA)
				lnk.rec_wdata <= pwdata[15:0];
			if (lnk.rec_done)
			begin
				lnk.rec_req <= 1'b0;
				rec_err_q   <= lnk.rec_err;
			end
			else if (wr && paddr == `PDI_REG_REC)
				lnk.rec_req <= 1'b1;
		end
endmodule : pdi_controller

// *** dv/pdi_link_props.sv ***
// Concurrent checks on the link between controller and device ends.
// Assumes one core clock; instantiated beside the link, no bind.
module pdi_link_props (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        resetn,
	// Link signals
	input wire logic        conn_req,
	input wire logic [6:0]  conn_module,
	input wire logic        conn_ack,
	input wire logic        conn_nak,
	input wire logic        conn_timeout,
	input wire logic        cyc_ack,
	input wire logic        rec_req,
	input wire logic [15:0] rec_index,
	input wire logic        rec_done,
	input wire logic        rec_err
);
	// ****************
	// Link properties
	// ****************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	AST_ONE_ANSWER: assert property (conn_ack |-> !conn_nak)
		else $error("connect acked and refused at once");
	AST_ANSWER_ON_REQ: assert property (
		conn_ack || conn_nak |=> !conn_req)
		else $error("connect request held after its answer");
	AST_BAD_MODULE: assert property (
		$rose(conn_req) && conn_module > 7'h54 |-> conn_nak)
		else $error("out of range module accepted");
	AST_REC_RESERVED: assert property (
		$rose(rec_req) && rec_index[15] |-> ##[1:60] rec_done && rec_err)
		else $error("reserved record index not refused");
	AST_CYC_PULSE: assert property (cyc_ack |=> !cyc_ack)
		else $error("cyclic ack longer than one cycle");
	AST_TMO_PULSE: assert property (conn_timeout |=> !conn_timeout)
		else $error("timeout longer than one cycle");
	AST_DONE_PULSE: assert property (rec_done |=> !rec_done)
		else $error("record done longer than one cycle");
	AST_TMO_QUIET: assert property (
		conn_timeout |-> !cyc_ack && !conn_ack)
		else $error("timeout while link is alive");
	cover property (cyc_ack);
	cover property (conn_nak);
	cover property (conn_timeout);
	cover property (rec_done && rec_err);
endmodule : pdi_link_props

// *** dv/profinet_drive_command_interpreter_test.sv ***
// Bench joining controller and device ends over the link.
// Assumes design package, header and link interface compiled first.
module test_profinet_drive_command_interpreter;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Stimulus and ends
	// ****************
	logic               core_clk = 0, resetn = 0, psel = 0, penable = 0;
	logic               pwrite = 0, map_we = 0, map_is_sts = 0, drv_ack = 0;
	logic               ready_on = 1, ready_run = 1, pready, pslverr, e;
	logic [11:0]        paddr = 0;
	logic [31:0]        pwdata = 0, prdata, q;
	logic [4:0]         map_idx = 0;
	logic [15:0]        map_reg = 0, drv_rdata = 0, drv_addr, drv_wdata;
	logic [15:0]        max_freq = 16'h1000;
	logic signed [15:0] out_freq = 16'sh0800, freq_cmd;
	logic               drv_req, drv_wr, run_cmd, ramp_enable, ramp_freeze;
	logic               fault_clear, remote_ctrl, comm_timeout;
	logic               coast_stop, quick_stop, op_en, sp_en, tel_mode;
	int                 err_total = 0, cmp_count = 0, fc_n = 0, wr_n = 0;
	pdi_link_if lnk();
	pdi_controller #(.TICK_CYCLES(4)) pdi_controller_inst (
		.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
	pdi_device #(.TICK_CYCLES(4)) pdi_device_inst (
		.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .lnk(lnk),
		.map_we(map_we), .map_is_sts(map_is_sts), .map_idx(map_idx),
		.map_reg(map_reg), .drv_req(drv_req), .drv_wr(drv_wr),
		.drv_addr(drv_addr), .drv_wdata(drv_wdata), .drv_ack(drv_ack),
		.drv_rdata(drv_rdata), .run_cmd(run_cmd),
		.coast_stop_request(coast_stop), .quick_stop_request(quick_stop),
		.op_enable(op_en), .setpoint_enable(sp_en),
		.ramp_enable(ramp_enable), .ramp_freeze(ramp_freeze),
		.fault_clear(fault_clear), .remote_ctrl(remote_ctrl),
		.freq_cmd(freq_cmd), .telegram_mode(tel_mode),
		.comm_timeout(comm_timeout),
		.max_freq(max_freq), .out_freq(out_freq), .ready_on(ready_on),
		.ready_run(ready_run));
	pdi_link_props pdi_link_props_inst (
		.core_clk(core_clk), .resetn(resetn), .conn_req(lnk.conn_req),
		.conn_module(lnk.conn_module), .conn_ack(lnk.conn_ack),
		.conn_nak(lnk.conn_nak), .conn_timeout(lnk.conn_timeout),
		.cyc_ack(lnk.cyc_ack), .rec_req(lnk.rec_req),
		.rec_index(lnk.rec_index), .rec_done(lnk.rec_done),
		.rec_err(lnk.rec_err));
	always #25 core_clk = ~core_clk;
	// Drive register responder, one-cycle acknowledge
	always @(posedge core_clk)
	begin
		drv_ack <= drv_req && !drv_ack;
		drv_rdata <= drv_addr ^ 16'h5a5a;
		if (drv_req && drv_wr && !drv_ack) wr_n++;
		if (fault_clear === 1'b1) fc_n++;
	end
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task fail;
		err_total++;
		report_and_stop;
	endtask : fail
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) fail();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task await(input bit s, input int k);
		int n;
		n = 0;
		while (k > 0)
		begin
			@(posedge core_clk);
			n++;
			if ((s ? lnk.rec_done : lnk.cyc_ack) === 1'b1) k--;
			if (n > 500) fail();
		end
	endtask : await
	task mp(input logic s, input logic [4:0] i, input logic [15:0] r);
		@(posedge core_clk);
		map_we <= 1'b1;
		map_is_sts <= s;
		map_idx <= i;
		map_reg <= r;
		@(posedge core_clk);
		map_we <= 1'b0;
	endtask : mp
	task t_regs;
		apb(1'b0, 12'h000, 32'h0);
		chk(q, 32'h0808_0000);
		apb(1'b0, 12'h020, 32'h0);
		chk({e, q[30:0]}, 32'h8000_0000);
		apb(1'b1, 12'h000, 32'h0803_5501);
		apb(1'b0, 12'h004, 32'h0);
		chk(q[1:0], 2'b10);
	endtask : t_regs
	task t_tel;
		apb(1'b1, 12'h040, 32'h047f);
		apb(1'b1, 12'h044, 32'h2000);
		apb(1'b1, 12'h000, 32'h0803_0003);
		await(1'b0, 2);
		chk({run_cmd, ramp_enable, ramp_freeze, remote_ctrl}, 4'hd);
		chk({coast_stop, quick_stop, op_en, sp_en, tel_mode}, 5'h07);
		chk(freq_cmd, 16'h0800);
		apb(1'b0, 12'h080, 32'h0);
		chk(q & 32'h33, 32'h33);
		apb(1'b0, 12'h084, 32'h0);
		chk(q, 32'h2000);
		ready_on <= 1'b0;
		fc_n = 0;
		apb(1'b1, 12'h040, 32'h04f9);
		await(1'b0, 3);
		chk(fc_n, 1);
		apb(1'b0, 12'h080, 32'h0);
		chk(q & 32'h33, 32'h02);
		apb(1'b1, 12'h040, 32'h0446);
		await(1'b0, 2);
		chk({ramp_enable, ramp_freeze}, 2'b01);
		chk(freq_cmd, 16'h0000);
		apb(1'b1, 12'h040, 32'h0030);
		await(1'b0, 2);
		chk({ramp_enable, ramp_freeze}, 2'b01);
	endtask : t_tel
	task t_wd;
		int n;
		apb(1'b1, 12'h000, 32'h0803_0000);
		n = 0;
		while (comm_timeout !== 1'b1 && n < 300)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n == 300) fail();
		chk(n > 92 && n < 135, 1);
		apb(1'b0, 12'h004, 32'h0);
		chk({q[2], q[0]}, 2'b10);
	endtask : t_wd
	task t_std;
		mp(1'b0, 5'h0, 16'h0);
		mp(1'b1, 5'h0, 16'h0021);
		mp(1'b1, 5'h1, 16'h0);
		wr_n = 0;
		apb(1'b1, 12'h000, 32'h0803_0103);
		await(1'b0, 2);
		chk(wr_n, 0);
		chk(tel_mode, 1'b0);
		apb(1'b0, 12'h080, 32'h0);
		chk(q, 32'h5a7b);
		apb(1'b0, 12'h084, 32'h0);
		chk(q, 32'h0);
	endtask : t_std
	task t_rec;
		apb(1'b1, 12'h00c, 32'h8001);
		await(1'b1, 1);
		chk(lnk.rec_err, 1);
		apb(1'b1, 12'h00c, 32'h0044);
		await(1'b1, 1);
		apb(1'b0, 12'h010, 32'h0);
		chk(q, 32'h5a1e);
	endtask : t_rec
	initial
	begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		t_regs;
		t_tel;
		t_wd;
		t_std;
		t_rec;
		report_and_stop;
	end
endmodule : test_profinet_drive_command_interpreter
